// ---- core/spe_pkg.sv ----
`default_nettype none
package spe_pkg;

  // Event flag set, one bit per sticky flag
  typedef struct packed {
    logic glb_fab;
    logic fab_int;
    logic bad_sym;
    logic bad_resp;
    logic ack_to;
    logic unrec;
    logic discard;
    logic repl_to;
    logic fab_to;
  } spe_flags_s;

  localparam int NFLAG = $bits(spe_flags_s);

  // Control symbol kinds on the receive side
  typedef enum logic [1:0] {
    SPE_CS_ACCEPT,
    SPE_CS_NOT_ACCEPT,
    SPE_CS_RETRY,
    SPE_CS_OTHER
  } spe_cs_kind_e;

  // Register byte offsets
  localparam logic [7:0] OFS_PORT_INT  = 8'h00;
  localparam logic [7:0] OFS_PORT_ERR  = 8'h04;
  localparam logic [7:0] OFS_ERR_DET   = 8'h08;
  localparam logic [7:0] OFS_FAB_INT   = 8'h0c;
  localparam logic [7:0] OFS_GLB_INT   = 8'h10;
  localparam logic [7:0] OFS_EVT_STAT  = 8'h14;
  localparam logic [7:0] OFS_INT_MASK  = 8'h18;
  localparam logic [7:0] OFS_PW_MASK   = 8'h1c;

  // Field positions inside the per-area registers
  localparam int PI_FAB_BIT     = 0;
  localparam int PI_REPL_BIT    = 1;
  localparam int PE_DISC_BIT    = 0;
  localparam int PE_UNREC_BIT   = 1;
  localparam int ED_ACKTO_BIT   = 0;
  localparam int ED_BADRESP_BIT = 1;
  localparam int ED_BADSYM_BIT  = 2;
  localparam int FI_FAB_BIT     = 0;
  localparam int GI_FAB_BIT     = 0;

  // Reset values
  localparam logic [NFLAG-1:0] FLAGS_RST    = 9'h000;
  localparam logic [NFLAG-1:0] INT_MASK_RST = 9'h000;
  localparam logic [NFLAG-1:0] PW_MASK_RST  = 9'h000;

  // Consecutive failed link-request tries that make a fatal error
  localparam int LR_FATAL_TRIES = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// ---- core/spe_streak_cnt.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_streak_cnt #(
  parameter int THRESH = spe_pkg::LR_FATAL_TRIES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic hit_i,
  input  wire logic clr_i,
  output logic      reached_o
);
  localparam int CW = $clog2(THRESH + 1);
  localparam logic [CW-1:0] LAST = CW'(THRESH - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          reached_r;
  logic          reached_nxt;

  always_comb begin
    cnt_nxt     = cnt_r;
    reached_nxt = 1'b0;
    if (clr_i) begin
      cnt_nxt = '0;
    end else if (hit_i) begin
      if (cnt_r == LAST) begin
        // Restart so a further run of tries is counted afresh
        cnt_nxt     = '0;
        reached_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r     <= '0;
      reached_r <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      reached_r <= reached_nxt;
    end
  end

  assign reached_o = reached_r;

  sequence s_last_try;
    hit_i && !clr_i && cnt_r == LAST;
  endsequence

  chk_streak_fires: assert property (@(posedge clk) disable iff (rst)
    s_last_try |=> reached_o && cnt_r == '0)
    else $error("streak end not flagged");

  chk_streak_cause: assert property (@(posedge clk) disable iff (rst)
    reached_o |-> $past(hit_i) && !$past(clr_i) && $past(cnt_r) == LAST)
    else $error("streak flagged without enough tries");

endmodule // spe_streak_cnt
`default_nettype wire

// ---- core/spe_port_err_events.sv ----
// Operation
// - Fabric request timeout raises fabric timeout event
// - Fabric timeout sets port, discard, fabric, global flags
// - Replication timeout sets replication timeout flag
// - Four tries with stray response: fatal
// - Four tries timing out: fatal
// - Lost link timer expiry: fatal
// - Any lane lock timer expiry: fatal
// - Fatal error sets unrecoverable port flag
// - Each response timeout sets ack timeout flag
// - Stray link response sets bad response flag
// - Unused ackID in accept, not-accept or retry symbol sets flag
`timescale 1ns/1ps
`default_nettype none
module spe_port_err_events #(
  parameter int ACKID_W = 6,
  parameter int LANES   = 4
) (
  input  wire logic                     SYS_CLK,
  input  wire logic                     RST,
  input  wire logic [7:0]               AWADDR,
  input  wire logic                     AWVALID,
  output logic                          AWREADY,
  input  wire logic [31:0]              WDATA,
  input  wire logic [3:0]               WSTRB,
  input  wire logic                     WVALID,
  output logic                          WREADY,
  output logic [1:0]                    BRESP,
  output logic                          BVALID,
  input  wire logic                     BREADY,
  input  wire logic [7:0]               ARADDR,
  input  wire logic                     ARVALID,
  output logic                          ARREADY,
  output logic [31:0]                   RDATA,
  output logic [1:0]                    RRESP,
  output logic                          RVALID,
  input  wire logic                     RREADY,
  input  wire logic                     FABRIC_TMO,
  input  wire logic                     REPL_TMO,
  input  wire logic                     LR_RESP_VALID,
  input  wire logic                     LR_RESP_NO_ACKID,
  input  wire logic                     LR_TMO,
  input  wire logic                     LOST_LINK_EXP,
  input  wire logic [LANES-1:0]         LANE_LOCK_EXP,
  input  wire logic                     CS_VALID,
  input  wire logic [1:0]               CS_KIND,
  input  wire logic [ACKID_W-1:0]       CS_ACKID,
  input  wire logic [(1<<ACKID_W)-1:0]  ACKID_INUSE,
  output logic                          IRQ,
  output logic                          PW_REQ
);

  localparam int NF = spe_pkg::NFLAG;

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] widen(input spe_pkg::spe_flags_s f);
    return {{(32-NF){1'b0}}, f};
  endfunction

  // Write-one-to-clear map from an address and its data to flags
  function automatic spe_pkg::spe_flags_s clr_map(input logic [7:0] a, input logic [31:0] d);
    spe_pkg::spe_flags_s c;
    c = '0;
    if (a == spe_pkg::OFS_PORT_INT) begin
      c.fab_to  = d[spe_pkg::PI_FAB_BIT];
      c.repl_to = d[spe_pkg::PI_REPL_BIT];
    end else if (a == spe_pkg::OFS_PORT_ERR) begin
      c.discard = d[spe_pkg::PE_DISC_BIT];
      c.unrec   = d[spe_pkg::PE_UNREC_BIT];
    end else if (a == spe_pkg::OFS_ERR_DET) begin
      c.ack_to   = d[spe_pkg::ED_ACKTO_BIT];
      c.bad_resp = d[spe_pkg::ED_BADRESP_BIT];
      c.bad_sym  = d[spe_pkg::ED_BADSYM_BIT];
    end else if (a == spe_pkg::OFS_FAB_INT) begin
      c.fab_int = d[spe_pkg::FI_FAB_BIT];
    end else if (a == spe_pkg::OFS_GLB_INT) begin
      c.glb_fab = d[spe_pkg::GI_FAB_BIT];
    end else if (a == spe_pkg::OFS_EVT_STAT) begin
      c = spe_pkg::spe_flags_s'(d[NF-1:0]);
    end
    return c;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == spe_pkg::OFS_PORT_INT || a == spe_pkg::OFS_PORT_ERR || a == spe_pkg::OFS_ERR_DET
        || a == spe_pkg::OFS_FAB_INT || a == spe_pkg::OFS_GLB_INT || a == spe_pkg::OFS_EVT_STAT
        || a == spe_pkg::OFS_INT_MASK || a == spe_pkg::OFS_PW_MASK;
  endfunction

  // Event detection
  spe_pkg::spe_flags_s flags_r;
  spe_pkg::spe_flags_s flags_nxt;
  spe_pkg::spe_flags_s set_v;
  spe_pkg::spe_flags_s clr_v;
  spe_pkg::spe_flags_s int_mask_r;
  spe_pkg::spe_flags_s int_mask_nxt;
  spe_pkg::spe_flags_s pw_mask_r;
  spe_pkg::spe_flags_s pw_mask_nxt;
  logic                stray_resp;
  logic                good_resp;
  logic                bad_symbol;
  logic                fatal;
  logic                resp_streak;
  logic                tmo_streak;

  always_comb begin
    stray_resp = LR_RESP_VALID && LR_RESP_NO_ACKID;
    good_resp  = LR_RESP_VALID && !LR_RESP_NO_ACKID;
    bad_symbol = CS_VALID && spe_pkg::spe_cs_kind_e'(CS_KIND) != spe_pkg::SPE_CS_OTHER
                 && !ACKID_INUSE[CS_ACKID];
  end

  // A different outcome breaks the run of the other kind
  spe_streak_cnt #(
    .THRESH (spe_pkg::LR_FATAL_TRIES)
  ) u_resp_streak (
    .clk       (SYS_CLK),
    .rst       (RST),
    .hit_i     (stray_resp),
    .clr_i     (good_resp || LR_TMO),
    .reached_o (resp_streak)
  );

  spe_streak_cnt #(
    .THRESH (spe_pkg::LR_FATAL_TRIES)
  ) u_tmo_streak (
    .clk       (SYS_CLK),
    .rst       (RST),
    .hit_i     (LR_TMO),
    .clr_i     (LR_RESP_VALID),
    .reached_o (tmo_streak)
  );

  always_comb begin
    fatal = resp_streak || tmo_streak || LOST_LINK_EXP || (|LANE_LOCK_EXP);
    set_v          = '0;
    set_v.fab_to   = FABRIC_TMO;
    set_v.discard  = FABRIC_TMO;
    set_v.fab_int  = FABRIC_TMO;
    set_v.glb_fab  = FABRIC_TMO;
    set_v.repl_to  = REPL_TMO;
    set_v.unrec    = fatal;
    set_v.ack_to   = LR_TMO;
    set_v.bad_resp = stray_resp;
    set_v.bad_sym  = bad_symbol;
  end

  // Register bus
  logic        aw_held_r;
  logic        aw_held_nxt;
  logic [7:0]  aw_addr_r;
  logic [7:0]  aw_addr_nxt;
  logic        w_held_r;
  logic        w_held_nxt;
  logic [31:0] w_data_r;
  logic [31:0] w_data_nxt;
  logic [3:0]  w_strb_r;
  logic [3:0]  w_strb_nxt;
  logic        bvalid_r;
  logic        bvalid_nxt;
  logic [1:0]  bresp_r;
  logic [1:0]  bresp_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0]  rresp_r;
  logic [1:0]  rresp_nxt;
  logic        do_wr;
  logic [31:0] wr_bits;
  logic [31:0] int_mask_w;
  logic [31:0] pw_mask_w;

  // One write at a time: both channels stall until the response leaves
  assign AWREADY = !aw_held_r && !bvalid_r;
  assign WREADY  = !w_held_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign do_wr   = aw_held_r && w_held_r;

  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt  = w_held_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (AWVALID && AWREADY) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = AWADDR;
    end
    if (WVALID && WREADY) begin
      w_held_nxt = 1'b1;
      w_data_nxt = WDATA;
      w_strb_nxt = WSTRB;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = is_mapped(aw_addr_r) ? spe_pkg::RESP_OKAY : spe_pkg::RESP_SLVERR;
    end else if (bvalid_r && BREADY) begin
      bvalid_nxt = 1'b0;
    end
  end

  always_comb begin
    wr_bits      = strb_merge(32'h0000_0000, w_data_r, w_strb_r);
    int_mask_w   = strb_merge(widen(int_mask_r), w_data_r, w_strb_r);
    pw_mask_w    = strb_merge(widen(pw_mask_r), w_data_r, w_strb_r);
    clr_v        = do_wr ? clr_map(aw_addr_r, wr_bits) : '0;
    int_mask_nxt = int_mask_r;
    pw_mask_nxt  = pw_mask_r;
    if (do_wr && aw_addr_r == spe_pkg::OFS_INT_MASK) begin
      int_mask_nxt = spe_pkg::spe_flags_s'(int_mask_w[NF-1:0]);
    end else if (do_wr && aw_addr_r == spe_pkg::OFS_PW_MASK) begin
      pw_mask_nxt = spe_pkg::spe_flags_s'(pw_mask_w[NF-1:0]);
    end
    // A new event outweighs a clear in the same cycle
    flags_nxt = (flags_r & ~clr_v) | set_v;
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (ARVALID && ARREADY) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = spe_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (ARADDR == spe_pkg::OFS_PORT_INT) begin
        rdata_nxt[spe_pkg::PI_FAB_BIT]  = flags_r.fab_to;
        rdata_nxt[spe_pkg::PI_REPL_BIT] = flags_r.repl_to;
      end else if (ARADDR == spe_pkg::OFS_PORT_ERR) begin
        rdata_nxt[spe_pkg::PE_DISC_BIT]  = flags_r.discard;
        rdata_nxt[spe_pkg::PE_UNREC_BIT] = flags_r.unrec;
      end else if (ARADDR == spe_pkg::OFS_ERR_DET) begin
        rdata_nxt[spe_pkg::ED_ACKTO_BIT]   = flags_r.ack_to;
        rdata_nxt[spe_pkg::ED_BADRESP_BIT] = flags_r.bad_resp;
        rdata_nxt[spe_pkg::ED_BADSYM_BIT]  = flags_r.bad_sym;
      end else if (ARADDR == spe_pkg::OFS_FAB_INT) begin
        rdata_nxt[spe_pkg::FI_FAB_BIT] = flags_r.fab_int;
      end else if (ARADDR == spe_pkg::OFS_GLB_INT) begin
        rdata_nxt[spe_pkg::GI_FAB_BIT] = flags_r.glb_fab;
      end else if (ARADDR == spe_pkg::OFS_EVT_STAT) begin
        rdata_nxt = widen(flags_r);
      end else if (ARADDR == spe_pkg::OFS_INT_MASK) begin
        rdata_nxt = widen(int_mask_r);
      end else if (ARADDR == spe_pkg::OFS_PW_MASK) begin
        rdata_nxt = widen(pw_mask_r);
      end else begin
        rresp_nxt = spe_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && RREADY) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      flags_r    <= spe_pkg::FLAGS_RST;
      int_mask_r <= spe_pkg::INT_MASK_RST;
      pw_mask_r  <= spe_pkg::PW_MASK_RST;
      aw_held_r  <= 1'b0;
      aw_addr_r  <= 8'h00;
      w_held_r   <= 1'b0;
      w_data_r   <= 32'h0000_0000;
      w_strb_r   <= 4'h0;
      bvalid_r   <= 1'b0;
      bresp_r    <= 2'h0;
      rvalid_r   <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      rresp_r    <= 2'h0;
    end else begin
      flags_r    <= flags_nxt;
      int_mask_r <= int_mask_nxt;
      pw_mask_r  <= pw_mask_nxt;
      aw_held_r  <= aw_held_nxt;
      aw_addr_r  <= aw_addr_nxt;
      w_held_r   <= w_held_nxt;
      w_data_r   <= w_data_nxt;
      w_strb_r   <= w_strb_nxt;
      bvalid_r   <= bvalid_nxt;
      bresp_r    <= bresp_nxt;
      rvalid_r   <= rvalid_nxt;
      rdata_r    <= rdata_nxt;
      rresp_r    <= rresp_nxt;
    end
  end

  assign BVALID = bvalid_r;
  assign BRESP  = bresp_r;
  assign RVALID = rvalid_r;
  assign RDATA  = rdata_r;
  assign RRESP  = rresp_r;
  assign IRQ    = |(flags_r & int_mask_r);
  assign PW_REQ = |(flags_r & pw_mask_r);

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  chk_fabric_flags: assert property (FABRIC_TMO |=>
    flags_r.fab_to && flags_r.discard && flags_r.fab_int && flags_r.glb_fab)
    else $error("fabric timeout flags not all set");

  chk_repl_flag: assert property (REPL_TMO |=> flags_r.repl_to)
    else $error("replication timeout not recorded");

  chk_lost_link: assert property (LOST_LINK_EXP |=> flags_r.unrec)
    else $error("lost link expiry not fatal");

  chk_lane_lock: assert property ((|LANE_LOCK_EXP) |=> flags_r.unrec)
    else $error("lane lock expiry not fatal");

  chk_unrec_cause: assert property ($rose(flags_r.unrec) |->
    $past(resp_streak || tmo_streak || LOST_LINK_EXP || (|LANE_LOCK_EXP)))
    else $error("unrecoverable flag without cause");

  chk_ack_timeout: assert property (LR_TMO |=> flags_r.ack_to)
    else $error("response timeout not recorded");

  chk_bad_response: assert property (LR_RESP_VALID && LR_RESP_NO_ACKID |=> flags_r.bad_resp)
    else $error("stray link response not recorded");

  chk_bad_symbol: assert property ($rose(flags_r.bad_sym) |-> $past(CS_VALID)
    && $past(CS_KIND) != 2'h3 && !$past(ACKID_INUSE[CS_ACKID]))
    else $error("bad symbol flag without cause");

  // A timeout in the same cycle breaks the run, so it is left out
  sequence s_last_stray;
    stray_resp && !LR_TMO && u_resp_streak.cnt_r == u_resp_streak.LAST;
  endsequence

  sequence s_streak_to_flag;
    resp_streak ##1 flags_r.unrec;
  endsequence

  chk_fatal_resp: assert property (s_last_stray |=> s_streak_to_flag)
    else $error("four stray responses not fatal");

  chk_irq_holds: assert property (IRQ && !do_wr && $stable(int_mask_r) |=> IRQ)
    else $error("interrupt dropped without clear");

  chk_pw_holds: assert property (PW_REQ && !do_wr |=> PW_REQ)
    else $error("port-write request dropped without clear");

endmodule // spe_port_err_events
`default_nettype wire

// ---- tb/spe_link_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module spe_link_partner (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       resp_go,
  input  wire logic       stray,
  input  wire logic       sym_go,
  input  wire logic [1:0] kind,
  input  wire logic [5:0] ackid,
  output logic            lr_valid,
  output logic            lr_no_ackid,
  output logic            cs_valid,
  output logic [1:0]      cs_kind,
  output logic [5:0]      cs_ackid
);
  // Idle payload fields (no-ackID, kind, ackID) flip every cycle so a stale value never passes as valid
  always_ff @(posedge clk) begin
    if (rst) begin
      lr_valid    <= 1'b0;
      cs_valid    <= 1'b0;
      lr_no_ackid <= 1'b0;
      cs_kind     <= 2'h0;
      cs_ackid    <= 6'h00;
    end else begin
      lr_valid    <= resp_go;
      cs_valid    <= sym_go;
      lr_no_ackid <= resp_go ? stray : ~lr_no_ackid;
      cs_kind     <= sym_go ? kind : ~cs_kind;
      cs_ackid    <= sym_go ? ackid : ~cs_ackid;
    end
  end
endmodule // spe_link_partner
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, a); end end
module tb_top;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, ev;
  logic [31:0] wdata, rdata, seed;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, irq, pw_req;
  logic [1:0]  bresp, rresp, kind, cs_kind;
  logic        resp_go, stray, sym_go, lr_valid, lr_no_ackid, cs_valid;
  logic [5:0]  ackid, cs_ackid;
  logic [63:0] inuse;
  logic [8:0]  expf, imask, pmask;
  int          sc, tc, error_cnt, check_count;

  spe_port_err_events #(.ACKID_W(6), .LANES(4)) dut (
    .SYS_CLK(clk), .RST(rst),
    .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .FABRIC_TMO(ev[0]), .REPL_TMO(ev[1]), .LR_TMO(ev[2]),
    .LR_RESP_VALID(lr_valid), .LR_RESP_NO_ACKID(lr_no_ackid),
    .LOST_LINK_EXP(ev[3]), .LANE_LOCK_EXP(ev[7:4]),
    .CS_VALID(cs_valid), .CS_KIND(cs_kind), .CS_ACKID(cs_ackid),
    .ACKID_INUSE(inuse), .IRQ(irq), .PW_REQ(pw_req)
  );

  spe_link_partner partner (
    .clk(clk), .rst(rst), .resp_go(resp_go), .stray(stray), .sym_go(sym_go),
    .kind(kind), .ackid(ackid), .lr_valid(lr_valid), .lr_no_ackid(lr_no_ackid),
    .cs_valid(cs_valid), .cs_kind(cs_kind), .cs_ackid(cs_ackid)
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] view(input logic [7:0] a);
    case (a)
      8'h00: return {30'h0, expf[1:0]};
      8'h04: return {30'h0, expf[3:2]};
      8'h08: return {29'h0, expf[6:4]};
      8'h0c: return {31'h0, expf[7]};
      8'h10: return {31'h0, expf[8]};
      8'h14: return {23'h0, expf};
      8'h18: return {23'h0, imask};
      8'h1c: return {23'h0, pmask};
      default: return 32'h0;
    endcase
  endfunction

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit ad, dd;
    ad = 0;
    dd = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      ad |= awready;
      dd |= wready;
      awvalid <= !ad;
      wvalid <= !dd;
    end
    do @(posedge clk); while (!bvalid);
    `CHK("bresp", (a > 8'h1c) ? spe_pkg::RESP_SLVERR : spe_pkg::RESP_OKAY, bresp)
  endtask

  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    `CHK("rdata", view(a), rdata)
    `CHK("rresp", (a > 8'h1c) ? spe_pkg::RESP_SLVERR : spe_pkg::RESP_OKAY, rresp)
  endtask

  // Flag set needs two cycles after a streak ends, so settle first
  task automatic chk();
    repeat (4) @(posedge clk);
    `CHK("irq", |(expf & imask), irq)
    `CHK("pw_req", |(expf & pmask), pw_req)
    for (int a = 0; a <= 32; a += 4) begin
      axr(8'(a));
    end
  endtask

  task automatic clr();
    axw(8'h14, 32'h1ff);
    expf = 9'h0;
    imask = 9'(rnd());
    pmask = ~imask;
    axw(8'h18, {23'h0, imask});
    axw(8'h1c, {23'h0, pmask});
  endtask

  task automatic fire(input logic [7:0] e, input logic rg, input logic st, input logic cg,
                      input logic [1:0] k, input logic [5:0] id);
    ev <= e;
    resp_go <= rg;
    stray <= st;
    sym_go <= cg;
    kind <= k;
    ackid <= id;
    @(posedge clk);
    ev <= 8'h0;
    resp_go <= 1'b0;
    sym_go <= 1'b0;
    @(posedge clk);
    if (e[0]) expf |= 9'h185;
    if (e[1]) expf |= 9'h002;
    if (|e[7:3]) expf |= 9'h008;
    if (e[2]) begin
      expf |= 9'h010;
      sc = 0;
      tc++;
      if (tc == spe_pkg::LR_FATAL_TRIES) begin
        expf |= 9'h008;
        tc = 0;
      end
    end
    if (rg) begin
      tc = 0;
      sc = st ? sc + 1 : 0;
      if (st) expf |= 9'h020;
      if (sc == spe_pkg::LR_FATAL_TRIES) begin
        expf |= 9'h008;
        sc = 0;
      end
    end
    if (cg && k != 2'h3 && !inuse[id]) expf |= 9'h040;
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {awaddr, araddr, awvalid, wvalid, arvalid, wdata, ev} = '0;
    {resp_go, stray, sym_go, kind, ackid, expf, imask, pmask} = '0;
    wstrb = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
    rst = 1'b1;
    seed = 32'd82;
    sc = 0;
    tc = 0;
    error_cnt = 0;
    check_count = 0;
    inuse = {rnd(), rnd()};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk();
    clr();
    fire(8'h01, 0, 0, 0, 0, 0);
    chk();
    fire(8'h02, 0, 0, 0, 0, 0);
    axw(8'h24, 32'h1ff);
    chk();
    clr();
    // Timeout run broken by a good response, then a full run of four
    repeat (3) fire(8'h04, 0, 0, 0, 0, 0);
    fire(8'h00, 1, 0, 0, 0, 0);
    repeat (3) fire(8'h04, 0, 0, 0, 0, 0);
    chk();
    fire(8'h04, 0, 0, 0, 0, 0);
    chk();
    axw(8'h04, 32'h2);
    expf[3] = 1'b0;
    chk();
    clr();
    repeat (3) fire(8'h00, 1, 1, 0, 0, 0);
    fire(8'h04, 0, 0, 0, 0, 0);
    repeat (4) fire(8'h00, 1, 1, 0, 0, 0);
    chk();
    clr();
    // Only the low byte of the mask may change
    wstrb <= 4'h1;
    axw(8'h18, 32'h1ff);
    wstrb <= 4'hf;
    imask[7:0] = 8'hff;
    chk();
    // Reset in mid-run must drop flags, masks and a half-done streak
    repeat (3) fire(8'h04, 0, 0, 0, 0, 0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    expf = 9'h0;
    imask = 9'h0;
    pmask = 9'h0;
    tc = 0;
    sc = 0;
    fire(8'h04, 0, 0, 0, 0, 0);
    chk();
    clr();
    for (int i = 3; i < 8; i++) begin
      fire(8'(1 << i), 0, 0, 0, 0, 0);
      chk();
      clr();
    end
    for (int k = 0; k < 4; k++) begin
      repeat (4) fire(8'h00, 0, 0, 1, 2'(k), 6'(rnd()));
      chk();
      clr();
    end
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
